// *** dv/sbc_host.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbc_host (
   input  wire logic             clk,
   input  wire logic [7:0]       rd_data,
   output var sbc_pkg::sbc_req_s req
);
   import sbc_pkg::*;
   // Quiet bus from time zero
   initial begin
      req = '0;
   end
   // single byte, held over the taking edge
   task automatic xfer(input logic w, input logic [6:0] a,
                       input logic [7:0] d, output logic [7:0] q);
      @(posedge clk);
      #1;
      req = '{wr: w, rd: ~w, addr: a, data: d};
      @(posedge clk);
      #1;
      q = rd_data;
      req = '{wr: 1'h0, rd: 1'h0, addr: ~a, data: ~d};
   endtask : xfer
endmodule : sbc_host
`default_nettype wire

// *** dv/sbc_mode_ctl_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module sbc_mode_ctl_asserts #(
   parameter int UNIT_CYCLES = 4,
   parameter int HOLD_CYCLES = 2
) (
   input wire logic               clk,
   input wire logic               sys_rst,
   input wire sbc_pkg::sbc_req_s  req,
   input wire sbc_pkg::sbc_evt_s  evt_async,
   input wire logic               forced_normal_cfg,
   input wire logic               wake_src_enabled,
   input wire logic               overflow_reset_flag,
   input wire logic               spi_fault_enable,
   input wire logic [7:0]         rd_data,
   input wire logic               rd_valid,
   input wire logic               spi_fault_event,
   input wire sbc_pkg::sbc_ctl_s  ctl,
   input wire sbc_pkg::sbc_mode_e mode,
   input wire sbc_pkg::sbc_wd_e   wd_state,
   input wire logic               wd_second_half
);
   import sbc_pkg::*;
   logic wd_dead;
   logic spi_up;
   // Modes where the watchdog rests, and modes taking access
   assign wd_dead = mode inside {SBC_OFF, SBC_RESET, SBC_OVERTEMP, SBC_FORCED};
   assign spi_up  = mode inside {SBC_STANDBY, SBC_NORMAL};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   // Steps of a mode write and of a register read
   sequence s_mode_wr(logic [2:0] code);
      req.wr && req.addr == 7'h01 && req.data[2:0] == code;
   endsequence
   sequence s_read(logic [6:0] a);
      req.rd && req.addr == a && spi_up;
   endsequence
   a_normal_select: assert property (
      mode == SBC_STANDBY ##0 s_mode_wr(3'h7)
      |=> mode == SBC_NORMAL && ctl.can_active)
      else $error("Normal request not honoured");
   a_bad_sleep: assert property (
      mode == SBC_STANDBY ##0 s_mode_wr(3'h1) ##0 !wake_src_enabled
      |=> mode == SBC_RESET)
      else $error("Sleep without wake source not refused");
   a_undef_code: assert property (
      mode == SBC_NORMAL && req.wr && req.addr == 7'h01
      && !(req.data[2:0] inside {3'h1, 3'h4, 3'h7}) |=> mode == SBC_NORMAL)
      else $error("Undefined mode code changed the mode");
   a_wd_rest: assert property (
      wd_dead && $past(wd_dead) |-> wd_state == SBC_WD_OFF)
      else $error("Watchdog active in a resting mode");
   a_win_normal: assert property (
      wd_state == SBC_WD_WIN |-> mode == SBC_NORMAL || $past(mode) == SBC_NORMAL)
      else $error("Window supervision outside Normal");
   a_win_deferred: assert property (
      mode == SBC_STANDBY && $past(mode) == SBC_STANDBY |-> wd_state != SBC_WD_WIN)
      else $error("Window supervision in Standby");
   a_mode_rsv: assert property (
      s_read(7'h01) |=> rd_valid && rd_data[7:3] == 5'h00)
      else $error("Mode register reserved bits not zero");
   a_status_rsv: assert property (
      s_read(7'h03) |=> rd_valid && !rd_data[7])
      else $error("Status reserved bit not zero");
   a_normal_flag: assert property (
      mode == SBC_NORMAL ##0 s_read(7'h03) |=> !rd_data[5])
      else $error("Normal entered flag still set in Normal");
   a_fault_pulse: assert property (
      spi_fault_event |=> !spi_fault_event)
      else $error("Fault event longer than one cycle");
   // block controls follow the selected mode
   a_ctl_standby: assert property (
      mode == SBC_STANDBY |-> ctl.v1_on && ctl.reset_out_high &&
      ctl.spi_active && !ctl.can_active && ctl.can_offline)
      else $error("Standby block controls wrong");
   // reset mode holds the host in reset
   a_ctl_reset: assert property (
      mode == SBC_RESET |-> ctl.v1_on && !ctl.reset_out_high &&
      !ctl.spi_active && !ctl.can_active)
      else $error("Reset block controls wrong");
   a_trig_restart: assert property (
      mode == SBC_STANDBY && req.wr && req.addr == 7'h00 &&
      req.data[7:5] inside {3'h1, 3'h2, 3'h4} &&
      req.data[3:0] inside {4'h8, 4'h1, 4'h2, 4'hB, 4'h4, 4'hD, 4'hE, 4'h7}
      |=> !wd_second_half)
      else $error("Trigger did not restart the timer");
   a_fault_gate: assert property (
      spi_fault_event |-> $past(spi_fault_enable))
      else $error("Fault event while disabled");
endmodule : sbc_mode_ctl_asserts
bind sbc_mode_ctl sbc_mode_ctl_asserts #(
   .UNIT_CYCLES(UNIT_CYCLES), .HOLD_CYCLES(HOLD_CYCLES)) u_asserts (
   .clk, .sys_rst, .req, .evt_async, .forced_normal_cfg, .wake_src_enabled,
   .overflow_reset_flag, .spi_fault_enable, .rd_data, .rd_valid,
   .spi_fault_event, .ctl, .mode, .wd_state, .wd_second_half);
`default_nettype wire

// *** dv/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   import sbc_pkg::*;
   // Case row: setup writes, event pulse, expected cause and faults
   typedef struct packed {
      logic [7:0] wd;
      logic [2:0] mc;
      logic [7:0] wd2;
      logic [7:0] ev;
      logic       ws;
      logic [4:0] rc;
      logic [7:0] fl;
   } sbc_tbrow_s;
   logic       clk;
   logic       sys_rst;
   sbc_req_s   req;
   sbc_evt_s   evt;
   logic       ws;
   logic       ofr;
   logic       fnc;
   logic       sfe;
   logic [7:0] rd_data;
   logic [7:0] q;
   logic       flt;
   sbc_mode_e  mode;
   sbc_wd_e    wd;
   int         failures;
   int         samples_checked;
   int         cyc;
   int         nflt;
   int         n0;
   sbc_tbrow_s rows [11] = '{
      '{8'h00, 3'h1, 8'h00, 8'h04, 1'h1, 5'h01, 8'h00}, // bus wake
      '{8'h00, 3'h1, 8'h00, 8'h02, 1'h1, 5'h04, 8'h00}, // pin wake
      '{8'h00, 3'h1, 8'h00, 8'h01, 1'h1, 5'h0D, 8'h00}, // diag wake
      '{8'h00, 3'h0, 8'h00, 8'h08, 1'h1, 5'h11, 8'h00}, // pull-down
      '{8'h00, 3'h0, 8'h00, 8'h10, 1'h1, 5'h13, 8'h00}, // undervolt
      '{8'h00, 3'h0, 8'h00, 8'h40, 1'h1, 5'h12, 8'h00}, // overtemp
      '{8'h00, 3'h1, 8'h00, 8'h00, 1'h0, 5'h14, 8'h00}, // no source
      '{8'h84, 3'h7, 8'h84, 8'h00, 1'h1, 5'h0E, 8'h00}, // early
      '{8'h84, 3'h7, 8'h00, 8'h00, 1'h1, 5'h0F, 8'h00}, // overflow
      '{8'h41, 3'h1, 8'h00, 8'h00, 1'h1, 5'h0C, 8'h00}, // sleep
      '{8'h44, 3'h7, 8'h41, 8'h00, 1'h1, 5'h10, 8'h01}  // change
   };
   sbc_mode_ctl #(.UNIT_CYCLES(4), .HOLD_CYCLES(2)) dut (
      .clk(clk), .sys_rst(sys_rst), .req(req), .evt_async(evt),
      .forced_normal_cfg(fnc), .wake_src_enabled(ws),
      .overflow_reset_flag(ofr), .spi_fault_enable(sfe),
      .rd_data(rd_data), .rd_valid(), .spi_fault_event(flt), .ctl(),
      .mode(mode), .wd_state(wd), .wd_second_half());
   sbc_host host (.clk(clk), .rd_data(rd_data), .req(req));
   // Clock generator
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   task automatic check(input string nm, input logic [7:0] seen,
                        input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic stop_test();
      if (failures == 0 && samples_checked > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : stop_test
   task automatic cycles(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cycles
   task automatic wait_mode(input sbc_mode_e m);
      int n;
      n = 0;
      while (mode !== m && n < 400) begin
         cycles(1);
         n++;
      end
      check("mode", {1'h0, mode}, {1'h0, m});
   endtask : wait_mode
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      host.xfer(1'h1, a, d, q);
   endtask : wr
   task automatic rd_chk(input string nm, input logic [6:0] a,
                         input logic [7:0] e);
      host.xfer(1'h0, a, 8'h00, q);
      check(nm, q, e);
   endtask : rd_chk
   // Cycle ceiling and fault pulse tally
   always @(posedge clk) begin
      cyc++;
      if (flt === 1'h1) nflt++;
      if (cyc == 20000) begin
         failures++;
         stop_test();
      end
   end
   // Power-up, table of cases, then hand-written cases
   initial begin
      sys_rst = 1'h1;
      evt = 8'h80;
      ws = 1'h1;
      ofr = 1'h0;
      fnc = 1'h0;
      sfe = 1'h1;
      failures = 0;
      samples_checked = 0;
      cyc = 0;
      nflt = 0;
      cycles(8);
      sys_rst = 1'h0;
      wait_mode(SBC_STANDBY);
      for (int i = 0; i < 11; i++) begin
         n0 = nflt;
         ws = rows[i].ws;
         if (rows[i].wd != 8'h00) wr(7'h00, rows[i].wd);
         if (rows[i].mc != 3'h0) wr(7'h01, {5'h00, rows[i].mc});
         if (rows[i].wd2 != 8'h00) wr(7'h00, rows[i].wd2);
         evt = evt | rows[i].ev;
         cycles(4);
         evt = evt & ~rows[i].ev;
         ws = 1'h1;
         wait_mode(SBC_STANDBY);
         host.xfer(1'h0, 7'h03, 8'h00, q);
         check("cause", {3'h0, q[4:0]}, {3'h0, rows[i].rc});
         check("fault", 8'(nflt - n0), rows[i].fl);
      end
      sys_rst = 1'h1;
      cycles(8);
      check("mode", {1'h0, mode}, {1'h0, SBC_OFF});
      sys_rst = 1'h0;
      wait_mode(SBC_STANDBY);
      rd_chk("status", 7'h03, 8'h20);
      rd_chk("wdog", 7'h00, 8'h44);
      check("wd", {4'h0, wd}, {4'h0, SBC_WD_TOUT});
      evt.temp_warn = 1'h1;
      cycles(4);
      rd_chk("status", 7'h03, 8'h60);
      evt.temp_warn = 1'h0;
      cycles(4);
      wr(7'h03, 8'hFF);
      rd_chk("status", 7'h03, 8'h20);
      n0 = nflt;
      wr(7'h00, 8'h64);
      wr(7'h00, 8'h49);
      sfe = 1'h0;
      wr(7'h00, 8'h64);
      sfe = 1'h1;
      rd_chk("wdog", 7'h00, 8'h44);
      check("fault", 8'(nflt - n0), 8'h02);
      wr(7'h00, 8'h84);
      cycles(2);
      check("wd", {4'h0, wd}, {4'h0, SBC_WD_TOUT});
      wr(7'h01, 8'hFF);
      check("mode", {1'h0, mode}, {1'h0, SBC_NORMAL});
      rd_chk("mode reg", 7'h01, 8'h07);
      check("wd", {4'h0, wd}, {4'h0, SBC_WD_WIN});
      rd_chk("status", 7'h03, 8'h00);
      wr(7'h01, 8'h02);
      check("mode", {1'h0, mode}, {1'h0, SBC_NORMAL});
      wr(7'h01, 8'h04);
      check("mode", {1'h0, mode}, {1'h0, SBC_STANDBY});
      cycles(2);
      check("wd", {4'h0, wd}, {4'h0, SBC_WD_TOUT});
      // Timeout overflow with the reset flag set
      ofr = 1'h1;
      wr(7'h00, 8'h41);
      wait_mode(SBC_RESET);
      wait_mode(SBC_STANDBY);
      ofr = 1'h0;
      rd_chk("status", 7'h03, 8'h0F);
      // Forced Normal after a reset, watchdog off, mode writes ignored
      fnc = 1'h1;
      evt.ext_reset = 1'h1;
      cycles(4);
      evt.ext_reset = 1'h0;
      wait_mode(SBC_FORCED);
      check("wd", {4'h0, wd}, {4'h0, SBC_WD_OFF});
      wr(7'h01, 8'h04);
      check("mode", {1'h0, mode}, {1'h0, SBC_FORCED});
      fnc = 1'h0;
      evt.ext_reset = 1'h1;
      cycles(4);
      evt.ext_reset = 1'h0;
      wait_mode(SBC_STANDBY);
      stop_test();
   end
endmodule : tb
`default_nettype wire

// *** src/sbc_defs.svh ***
`ifndef SBC_DEFS_SVH
`define SBC_DEFS_SVH
// Register addresses on the 8-bit serial register port
`define SBC_ADDR_WDOG    7'h00
`define SBC_ADDR_MODE    7'h01
`define SBC_ADDR_STATUS  7'h03
// Mode select codes
`define SBC_MC_SLEEP     3'h1
`define SBC_MC_STANDBY   3'h4
`define SBC_MC_NORMAL    3'h7
// Watchdog behaviour codes
`define SBC_WM_AUTO      3'h1
`define SBC_WM_TIMEOUT   3'h2
`define SBC_WM_WINDOW    3'h4
// Watchdog period codes
`define SBC_WP_8         4'h8
`define SBC_WP_16        4'h1
`define SBC_WP_32        4'h2
`define SBC_WP_64        4'hB
`define SBC_WP_128       4'h4
`define SBC_WP_256       4'hD
`define SBC_WP_1024      4'hE
`define SBC_WP_4096      4'h7
// Reset cause codes
`define SBC_RC_POWERON   5'h00
`define SBC_RC_CANWAKE   5'h01
`define SBC_RC_PINWAKE   5'h04
`define SBC_RC_SLP_OVF   5'h0C
`define SBC_RC_DIAGWAKE  5'h0D
`define SBC_RC_EARLY     5'h0E
`define SBC_RC_OVERFLOW  5'h0F
`define SBC_RC_ILL_WDOG  5'h10
`define SBC_RC_EXT_RST   5'h11
`define SBC_RC_OVERTEMP  5'h12
`define SBC_RC_UNDERVOLT 5'h13
`define SBC_RC_ILL_SLEEP 5'h14
// Status bit positions
`define SBC_ST_OTW_BIT   6
`define SBC_ST_NORM_BIT  5
// Timing
`define SBC_CLK_HZ       50000000
`define SBC_MS_PER_UNIT  8
`define SBC_RST_HOLD_US  20
`endif

// *** src/sbc_mode_ctl.sv ***
// Function
// RQ1: Mode field at 0x01: 001 Sleep, 100 Standby, 111 Normal.
// RQ2: Watchdog off in Off, Forced Normal, Reset, Overtemp; else per field.
// RQ3: Window supervision runs only in Normal mode.
// RQ4: Status bit 6 mirrors the temperature warning level.
// RQ5: Status bit 5 reads 1 until Normal is first entered.
// RQ6: Status bits 4:0 hold cause of most recent reset.
// RQ7: Cause 00000 on leaving Off, 10010 on leaving Overtemp.
// RQ8: Sleep wakes: CAN 00001, pin 00100, diagnostic 01101.
// RQ9: Overflow in Sleep with timeout behaviour gives 01100.
// RQ10: Early trigger in window 01110; overflow 01111.
// RQ11: External reset pull-down 10001, supply undervoltage 10011.
// RQ12: Illegal Sleep request records 10100.
// RQ13: Window, timeout, autonomous; window restarts only when open.
// RQ14: Timeout counts continuously; any trigger restarts it.
// RQ15: Host changes watchdog settings only in Standby.
// RQ16: Window setting acts as timeout until Normal entered.
// RQ17: Watchdog change in Normal forces Reset, cause 10000, fault.
// RQ18: Eight periods 8 to 4096 ms, default 128 ms.
// RQ19: Sleep with wake pending or no source gives Reset, 10100.
// RQ20: Every valid watchdog write restarts timer; new values immediate.
// RQ21: Invalid watchdog codes abandon the write and raise fault.
// RQ22: Status writes and reserved bits ignored; reserved read zero.
// RQ23: Undefined mode codes leave the mode unchanged.
`include "sbc_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module sbc_mode_ctl #(
   parameter int UNIT_CYCLES = (`SBC_CLK_HZ / 1000) * `SBC_MS_PER_UNIT,
   parameter int HOLD_CYCLES = (`SBC_CLK_HZ / 1000000) * `SBC_RST_HOLD_US
) (
   input  wire logic              clk,
   input  wire logic              sys_rst,
   input  wire sbc_pkg::sbc_req_s req,
   input  wire sbc_pkg::sbc_evt_s evt_async,
   input  wire logic              forced_normal_cfg,
   input  wire logic              wake_src_enabled,
   input  wire logic              overflow_reset_flag,
   input  wire logic              spi_fault_enable,
   output logic [7:0]             rd_data,
   output logic                   rd_valid,
   output logic                   spi_fault_event,
   output sbc_pkg::sbc_ctl_s      ctl,
   output sbc_pkg::sbc_mode_e     mode,
   output sbc_pkg::sbc_wd_e       wd_state,
   output logic                   wd_second_half
);
   import sbc_pkg::*;

   initial begin
      if (UNIT_CYCLES < 2 || HOLD_CYCLES < 1)
         $error("sbc_mode_ctl: unit or hold count too small");
   end

   // Two-flop synchronisers on event inputs
   sbc_evt_s evt_m_r, evt_s_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         evt_m_r <= '0;
         evt_s_r <= '0;
      end else begin
         evt_m_r <= evt_async;
         evt_s_r <= evt_m_r;
      end
   end

   // Period code to 8 ms units
   function automatic logic [9:0] period_units(input logic [3:0] c);
      unique case (c)
         `SBC_WP_8:    period_units = 10'd1;
         `SBC_WP_16:   period_units = 10'd2;
         `SBC_WP_32:   period_units = 10'd4;
         `SBC_WP_64:   period_units = 10'd8;
         `SBC_WP_256:  period_units = 10'd32;
         `SBC_WP_1024: period_units = 10'd128;
         `SBC_WP_4096: period_units = 10'd512;
         default:      period_units = 10'd16;
      endcase
   endfunction : period_units

   function automatic logic period_ok(input logic [3:0] c);
      period_ok = (c == `SBC_WP_8) || (c == `SBC_WP_16) ||
                  (c == `SBC_WP_32) || (c == `SBC_WP_64) ||
                  (c == `SBC_WP_128) || (c == `SBC_WP_256) ||
                  (c == `SBC_WP_1024) || (c == `SBC_WP_4096);
   endfunction : period_ok

   // State registers
   sbc_mode_e  mode_r, mode_nxt;
   logic [2:0] mc_r, mc_nxt;
   logic [2:0] wmc_r, wmc_nxt;
   logic [3:0] nwp_r, nwp_nxt;
   logic [4:0] cause_r, cause_nxt;
   logic       norm_pend_r, norm_pend_nxt;
   logic [31:0] tick_r, tick_nxt;
   logic [9:0] units_r, units_nxt;
   logic [31:0] hold_r, hold_nxt;
   logic [7:0] rd_data_r, rd_data_nxt;
   logic       rd_valid_r, rd_valid_nxt;
   logic       fault_r, fault_nxt;
   sbc_wd_e    wd_r, wd_nxt;
   logic       half_r, half_nxt;
   logic       wake_pend;
   logic       wd_write, wd_valid;
   logic [9:0] per_units;
   logic       overflow;

   assign wake_pend = evt_s_r.can_wake | evt_s_r.pin_wake |
                      evt_s_r.diag_wake;
   assign wd_write  = req.wr && (req.addr == `SBC_ADDR_WDOG);
   // RQ21 invalid codes
   assign wd_valid  = ((req.data[7:5] == `SBC_WM_AUTO) ||
                       (req.data[7:5] == `SBC_WM_TIMEOUT) ||
                       (req.data[7:5] == `SBC_WM_WINDOW)) &&
                      period_ok(req.data[3:0]);
   // RQ18 period select
   assign per_units = period_units(nwp_r);
   assign overflow  = (units_r >= per_units) && (wd_r != SBC_WD_OFF);

   // Next-state logic for modes, watchdog and registers
   always_comb begin
      mode_nxt      = mode_r;
      mc_nxt        = mc_r;
      wmc_nxt       = wmc_r;
      nwp_nxt       = nwp_r;
      cause_nxt     = cause_r;
      norm_pend_nxt = norm_pend_r;
      tick_nxt      = tick_r + 32'd1;
      units_nxt     = units_r;
      hold_nxt      = hold_r;
      rd_valid_nxt  = req.rd;
      rd_data_nxt   = 8'h00;
      fault_nxt     = 1'b0;
      if (tick_r >= 32'(UNIT_CYCLES - 1)) begin
         tick_nxt  = '0;
         units_nxt = units_r + 10'd1;
      end
      // Register reads; reserved bits zero
      // RQ22 reserved zero
      unique case (req.addr)
         `SBC_ADDR_WDOG:   rd_data_nxt = {wmc_r, 1'b0, nwp_r};
         `SBC_ADDR_MODE:   rd_data_nxt = {5'h00, mc_r};
         // RQ4 warning bit
         `SBC_ADDR_STATUS: begin
            rd_data_nxt = {1'b0, evt_s_r.temp_warn, norm_pend_r, cause_r};
         end
         default:          rd_data_nxt = 8'h00;
      endcase
      if (!req.rd)
         rd_data_nxt = 8'h00;
      // Per-mode transitions
      unique case (mode_r)
         SBC_OFF: begin
            if (evt_s_r.power_ok) begin
               mode_nxt  = SBC_RESET;
               // RQ7 power-on code
               cause_nxt = `SBC_RC_POWERON;
               hold_nxt  = '0;
            end
         end
         SBC_OVERTEMP: begin
            if (!evt_s_r.overtemp) begin
               mode_nxt  = SBC_RESET;
               // RQ7 overtemp exit
               cause_nxt = `SBC_RC_OVERTEMP;
               hold_nxt  = '0;
            end
         end
         SBC_RESET: begin
            if (!evt_s_r.v1_under) begin
               hold_nxt = hold_r + 32'd1;
            end
            if (hold_r >= 32'(HOLD_CYCLES - 1) && !evt_s_r.v1_under &&
                !evt_s_r.ext_reset) begin
               mode_nxt = forced_normal_cfg ? SBC_FORCED : SBC_STANDBY;
               mc_nxt   = `SBC_MC_STANDBY;
               tick_nxt = '0;
               units_nxt = '0;
            end
         end
         SBC_SLEEP: begin
            // RQ8 wake codes
            if (evt_s_r.can_wake || evt_s_r.pin_wake ||
                evt_s_r.diag_wake) begin
               mode_nxt  = SBC_RESET;
               hold_nxt  = '0;
               cause_nxt = evt_s_r.can_wake ? `SBC_RC_CANWAKE :
                           evt_s_r.pin_wake ? `SBC_RC_PINWAKE :
                                              `SBC_RC_DIAGWAKE;
            // RQ9 sleep overflow
            end else if (overflow) begin
               mode_nxt  = SBC_RESET;
               hold_nxt  = '0;
               cause_nxt = `SBC_RC_SLP_OVF;
            end
         end
         default: begin
            // Standby and Normal take host writes; Forced Normal ignores them
            if (req.wr && req.addr == `SBC_ADDR_MODE &&
                mode_r != SBC_FORCED) begin
               // RQ1 mode select
               unique case (req.data[2:0])
                  `SBC_MC_SLEEP: begin
                     // RQ19 illegal sleep
                     if (wake_pend || !wake_src_enabled) begin
                        mode_nxt  = SBC_RESET;
                        hold_nxt  = '0;
                        // RQ12 illegal code
                        cause_nxt = `SBC_RC_ILL_SLEEP;
                     end else begin
                        mode_nxt = SBC_SLEEP;
                        mc_nxt   = `SBC_MC_SLEEP;
                     end
                  end
                  `SBC_MC_STANDBY: begin
                     mode_nxt = SBC_STANDBY;
                     mc_nxt   = `SBC_MC_STANDBY;
                  end
                  `SBC_MC_NORMAL: begin
                     mode_nxt      = SBC_NORMAL;
                     mc_nxt        = `SBC_MC_NORMAL;
                     // RQ5 normal entered
                     norm_pend_nxt = 1'b0;
                  end
                  // RQ23 undefined codes
                  default: mode_nxt = mode_r;
               endcase
            end
            if (wd_write && mode_r != SBC_FORCED) begin
               if (!wd_valid) begin
                  // RQ21 abandon write
                  fault_nxt = spi_fault_enable;
               end else if (mode_r == SBC_NORMAL &&
                            (req.data[7:5] != wmc_r ||
                             req.data[3:0] != nwp_r)) begin
                  // RQ17 illegal change
                  mode_nxt  = SBC_RESET;
                  hold_nxt  = '0;
                  cause_nxt = `SBC_RC_ILL_WDOG;
                  fault_nxt = spi_fault_enable;
               end else begin
                  // RQ20 trigger restart
                  wmc_nxt   = req.data[7:5];
                  nwp_nxt   = req.data[3:0];
                  tick_nxt  = '0;
                  units_nxt = '0;
                  // RQ13 early trigger
                  if (wd_r == SBC_WD_WIN && !half_r) begin
                     mode_nxt  = SBC_RESET;
                     hold_nxt  = '0;
                     // RQ10 early code
                     cause_nxt = `SBC_RC_EARLY;
                  end
               end
            end else if (overflow && (wd_r == SBC_WD_WIN ||
                                      overflow_reset_flag)) begin
               // RQ10 overflow code
               mode_nxt  = SBC_RESET;
               hold_nxt  = '0;
               cause_nxt = `SBC_RC_OVERFLOW;
            end else if (overflow) begin
               // RQ14 timeout restart
               tick_nxt  = '0;
               units_nxt = '0;
            end
            // RQ11 external and supply
            if (evt_s_r.ext_reset) begin
               mode_nxt  = SBC_RESET;
               hold_nxt  = '0;
               cause_nxt = `SBC_RC_EXT_RST;
            end
            if (evt_s_r.v1_under) begin
               mode_nxt  = SBC_RESET;
               hold_nxt  = '0;
               cause_nxt = `SBC_RC_UNDERVOLT;
            end
         end
      endcase
      if (mode_r != SBC_OFF && mode_r != SBC_SLEEP && evt_s_r.overtemp)
         mode_nxt = SBC_OVERTEMP;
      if (!evt_s_r.power_ok)
         mode_nxt = SBC_OFF;
      // RQ5 power loss rearms
      if (mode_nxt == SBC_OFF)
         norm_pend_nxt = 1'b1;
   end

   // Effective watchdog behaviour per mode
   always_comb begin
      wd_nxt   = SBC_WD_OFF;
      // Half flag follows the restarted timer and the new period
      half_nxt = (units_nxt >= (period_units(nwp_nxt) >> 1));
      unique case (mode_nxt)
         // RQ3 window in normal
         SBC_NORMAL: begin
            wd_nxt = (wmc_nxt == `SBC_WM_WINDOW) ? SBC_WD_WIN : SBC_WD_TOUT;
         end
         // RQ16 window as timeout
         SBC_STANDBY, SBC_SLEEP: begin
            if (wmc_nxt == `SBC_WM_WINDOW || wmc_nxt == `SBC_WM_TIMEOUT)
               wd_nxt = SBC_WD_TOUT;
            else if (wake_pend && mode_nxt == SBC_STANDBY)
               wd_nxt = SBC_WD_TOUT;
         end
         // RQ2 watchdog off
         default: wd_nxt = SBC_WD_OFF;
      endcase
   end

   // Register all state
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode_r      <= SBC_OFF;
         mc_r        <= `SBC_MC_STANDBY;
         wmc_r       <= `SBC_WM_TIMEOUT;
         nwp_r       <= `SBC_WP_128;
         cause_r     <= `SBC_RC_POWERON;
         norm_pend_r <= 1'b1;
         tick_r      <= '0;
         units_r     <= '0;
         hold_r      <= '0;
         rd_data_r   <= 8'h00;
         rd_valid_r  <= 1'b0;
         fault_r     <= 1'b0;
         wd_r        <= SBC_WD_OFF;
         half_r      <= 1'b0;
      end else begin
         mode_r      <= mode_nxt;
         mc_r        <= mc_nxt;
         wmc_r       <= wmc_nxt;
         nwp_r       <= nwp_nxt;
         cause_r     <= cause_nxt;
         norm_pend_r <= norm_pend_nxt;
         tick_r      <= tick_nxt;
         units_r     <= units_nxt;
         hold_r      <= hold_nxt;
         rd_data_r   <= rd_data_nxt;
         rd_valid_r  <= rd_valid_nxt;
         fault_r     <= fault_nxt;
         wd_r        <= wd_nxt;
         half_r      <= half_nxt;
      end
   end

   // Per-mode block controls, registered
   sbc_ctl_s ctl_r;
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctl_r <= '0;
      end else begin
         ctl_r.v1_on          <= !(mode_nxt inside {SBC_OFF, SBC_SLEEP,
                                                    SBC_OVERTEMP});
         ctl_r.reset_out_high <= mode_nxt inside {SBC_FORCED, SBC_STANDBY,
                                                  SBC_NORMAL};
         ctl_r.spi_active     <= mode_nxt inside {SBC_FORCED, SBC_STANDBY,
                                                  SBC_NORMAL};
         ctl_r.can_active     <= mode_nxt inside {SBC_FORCED, SBC_NORMAL};
         ctl_r.can_offline    <= mode_nxt inside {SBC_STANDBY, SBC_SLEEP,
                                                  SBC_RESET};
         ctl_r.aux_on         <= !(mode_nxt inside {SBC_OFF, SBC_OVERTEMP});
      end
   end

   assign rd_data         = rd_data_r;
   assign rd_valid        = rd_valid_r;
   assign spi_fault_event = fault_r;
   assign ctl             = ctl_r;
   assign mode            = mode_r;
   assign wd_state        = wd_r;
   assign wd_second_half  = half_r;
endmodule : sbc_mode_ctl
`default_nettype wire

// *** src/sbc_pkg.sv ***
package sbc_pkg;
   // Operating modes, one-hot
   typedef enum logic [6:0] {
      SBC_OFF      = 7'b0000001,
      SBC_RESET    = 7'b0000010,
      SBC_STANDBY  = 7'b0000100,
      SBC_NORMAL   = 7'b0001000,
      SBC_SLEEP    = 7'b0010000,
      SBC_OVERTEMP = 7'b0100000,
      SBC_FORCED   = 7'b1000000
   } sbc_mode_e;
   // Effective watchdog behaviour
   typedef enum logic [3:0] {
      SBC_WD_OFF   = 4'b0001,
      SBC_WD_TOUT  = 4'b0010,
      SBC_WD_WIN   = 4'b0100,
      SBC_WD_SPARE = 4'b1000
   } sbc_wd_e;
   // Register read or write request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] data;
   } sbc_req_s;
   // Per-mode block controls
   typedef struct packed {
      logic v1_on;
      logic reset_out_high;
      logic spi_active;
      logic can_active;
      logic can_offline;
      logic aux_on;
   } sbc_ctl_s;
   // Asynchronous event inputs
   typedef struct packed {
      logic power_ok;
      logic overtemp;
      logic temp_warn;
      logic v1_under;
      logic ext_reset;
      logic can_wake;
      logic pin_wake;
      logic diag_wake;
   } sbc_evt_s;
endpackage : sbc_pkg
